/* src/cfc_regs.sv */
// cfc_regs: apb register bank for defect correction, exposure and trigger control
// assumes synchronous inputs on pclk and a single clock domain
//
// Local design decision: the APB register port.
`timescale 1ns/1ns
module cfc_regs
  import cfc_pkg::*;
#(
  parameter int          PIN_COUNT        = 8,
  parameter logic        DEFECT_PRESENT   = 1'b1,
  parameter logic        EXPOSURE_PRESENT = 1'b1,
  parameter logic        TRIG_PRESENT     = 1'b1,
  parameter logic        DELAY_PRESENT    = 1'b1,
  parameter logic        EXTENDED_EXPO    = 1'b1,
  parameter logic [11:0] DEFECT_MAX_PIX   = 12'h0400
) (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [12:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic                      pslverr,
  output logic [31:0]               prdata,
  // feature logic inputs
  input  wire logic [11:0]          defect_cur_pixels,
  input  wire logic [11:0]          abs_exposure_value,
  input  wire logic [11:0]          auto_exposure_value,
  input  wire logic                 one_push_done,
  input  wire logic                 trigger_done,
  input  wire logic [PIN_COUNT-1:0] gpio_in,
  // feature logic outputs
  output logic                      defect_corr_en,
  output logic                      exposure_en,
  output logic                      exposure_auto,
  output logic [15:0]               exposure_value,
  output logic                      abs_exposure_ro,
  output logic                      one_push_start,
  output logic                      trigger_fire,
  output logic                      trigger_en,
  output logic [3:0]                trigger_mode,
  output logic [11:0]               trigger_param,
  output logic [11:0]               trigger_delay
);

  //////////////////////////////////////////////////////////////////////////////
  cfc_state_t s_reg;
  cfc_state_t s_next;

  function automatic logic addr_known(input logic [12:0] a);
    return (a == CFC_SOFT_FIRE_ADDR) || (a == CFC_EXPOSURE_ADDR) || (a == CFC_TRIG_BEHAV_ADDR) ||
           (a == CFC_TRIG_DELAY_ADDR) || (a == CFC_DEFECT_ADDR);
  endfunction

  logic        setup_ph;
  logic        wr_acc;
  logic        pin_level;
  logic        pin_active;
  logic        ext_event;
  logic [31:0] rd_word;

  assign setup_ph  = psel && !penable;
  assign wr_acc    = psel && penable && s_reg.pready && pwrite && addr_known(paddr);
  // out-of-range source ids read as a low pin
  assign pin_level = (int'(s_reg.trig.source) < PIN_COUNT) ? gpio_in[s_reg.trig.source] : 1'b0;
  assign pin_active = pin_level ~^ s_reg.trig.polarity;
  assign ext_event  = s_reg.trig.on && pin_active && !s_reg.trig.raw_active_d;

  //////////////////////////////////////////////////////////////////////////////
  // reserved bits zero
  always_comb begin
    rd_word = CFC_RDATA_RST;
    case (paddr)
      CFC_DEFECT_ADDR: begin
        rd_word[CFC_PRESENT_BIT] = DEFECT_PRESENT;
        rd_word[CFC_ON_BIT] = s_reg.defect_on;
        rd_word[CFC_MAXPIX_LSB +: 12] = DEFECT_MAX_PIX;
        rd_word[CFC_VALUE_LSB +: 12] = defect_cur_pixels;
      end
      CFC_EXPOSURE_ADDR: begin
        rd_word[CFC_PRESENT_BIT]  = EXPOSURE_PRESENT;
        rd_word[CFC_ABS_BIT]      = s_reg.expo.abs_ctl;
        rd_word[CFC_ONE_PUSH_BIT] = s_reg.expo.one_push;
        rd_word[CFC_ON_BIT]       = s_reg.expo.on;
        rd_word[CFC_AUTO_BIT]     = s_reg.expo.auto_mode;
        // upper bits only with extended exposure
        rd_word[CFC_HIGH_LSB +: 4] = EXTENDED_EXPO ? s_reg.expo.high : 4'h0;
        rd_word[CFC_VALUE_LSB +: 12] = s_reg.expo.value;
      end
      CFC_SOFT_FIRE_ADDR: begin
        rd_word[CFC_FIRE_BIT] = s_reg.busy;
      end
      CFC_TRIG_DELAY_ADDR: begin
        rd_word[CFC_PRESENT_BIT]     = DELAY_PRESENT;
        rd_word[CFC_ABS_BIT]         = s_reg.dly.abs_ctl;
        rd_word[CFC_ON_BIT]          = s_reg.dly.on;
        rd_word[CFC_VALUE_LSB +: 12] = s_reg.dly.value;
      end
      CFC_TRIG_BEHAV_ADDR: begin
        rd_word[CFC_PRESENT_BIT]     = TRIG_PRESENT;
        rd_word[CFC_ABS_BIT]         = s_reg.trig.abs_ctl;
        rd_word[CFC_ON_BIT]          = s_reg.trig.on;
        rd_word[CFC_POL_BIT]         = s_reg.trig.polarity;
        rd_word[CFC_SRC_LSB +: 3]    = s_reg.trig.source;
        rd_word[CFC_RAW_BIT]         = s_reg.trig.raw;
        rd_word[CFC_MODE_LSB +: 4]   = s_reg.trig.mode;
        rd_word[CFC_VALUE_LSB +: 12] = s_reg.trig.param;
      end
      default: rd_word = CFC_RDATA_RST;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_next = s_reg;
    // zero-wait apb: ready one cycle after setup, read data captured at setup
    s_next.pready  = setup_ph;
    s_next.pslverr = setup_ph && !addr_known(paddr);
    s_next.prdata  = setup_ph ? rd_word : CFC_RDATA_RST;
    s_next.fire       = 1'b0;
    s_next.push_start = 1'b0;
    s_next.trig.raw          = pin_level;
    s_next.trig.raw_active_d = pin_active;

    // auto state: controller value tracks in
    if (s_reg.expo.on && s_reg.expo.auto_mode) begin
      s_next.expo.value = auto_exposure_value;
    end else if (s_reg.expo.on && s_reg.expo.abs_ctl) begin
      s_next.expo.value = abs_exposure_value;
    end

    if (one_push_done) begin
      s_next.expo.one_push = 1'b0;
    end

    if (trigger_done && s_reg.trig.mode != CFC_STICKY_MODE) begin
      s_next.busy = 1'b0;
    end

    if (wr_acc) begin
      case (paddr)
        CFC_DEFECT_ADDR: begin
          s_next.defect_on = pwdata[CFC_ON_BIT];
        end
        CFC_EXPOSURE_ADDR: begin
          s_next.expo.on = pwdata[CFC_ON_BIT];
          if (s_reg.expo.on) begin
            s_next.expo.abs_ctl = pwdata[CFC_ABS_BIT];
            s_next.expo.auto_mode = pwdata[CFC_AUTO_BIT];
            if (pwdata[CFC_ONE_PUSH_BIT] && !s_reg.expo.auto_mode && !pwdata[CFC_AUTO_BIT]) begin
              s_next.expo.one_push = 1'b1;
              s_next.push_start    = 1'b1;
            end
            // value writable only in plain manual
            if (!s_reg.expo.auto_mode && !s_reg.expo.abs_ctl) begin
              s_next.expo.value = pwdata[CFC_VALUE_LSB +: 12];
              if (EXTENDED_EXPO) begin
                s_next.expo.high = pwdata[CFC_HIGH_LSB +: 4];
              end
            end
          end
        end
        CFC_SOFT_FIRE_ADDR: begin
          if (pwdata[CFC_FIRE_BIT]) begin
            s_next.busy = 1'b1;
            s_next.fire = 1'b1;
          end else if (!ext_event) begin
            s_next.busy = 1'b0;
          end
        end
        CFC_TRIG_DELAY_ADDR: begin
          s_next.dly.on = pwdata[CFC_ON_BIT];
          if (s_reg.dly.on) begin
            s_next.dly.abs_ctl = pwdata[CFC_ABS_BIT];
            if (!s_reg.dly.abs_ctl) begin
              s_next.dly.value = pwdata[CFC_VALUE_LSB +: 12];
            end
          end
        end
        CFC_TRIG_BEHAV_ADDR: begin
          s_next.trig.on = pwdata[CFC_ON_BIT];
          if (s_reg.trig.on) begin
            s_next.trig.abs_ctl  = pwdata[CFC_ABS_BIT];
            s_next.trig.polarity = pwdata[CFC_POL_BIT];
            s_next.trig.source   = pwdata[CFC_SRC_LSB +: 3];
            s_next.trig.mode     = pwdata[CFC_MODE_LSB +: 4];
            if (!s_reg.trig.abs_ctl) begin
              s_next.trig.param = pwdata[CFC_VALUE_LSB +: 12];
            end
          end
        end
        default: s_next.dly = s_reg.dly;
      endcase
    end

    // external trigger also marks busy; set wins over clear
    if (ext_event) begin
      s_next.busy = 1'b1;
      s_next.fire = 1'b1;
    end

    s_next.delay_out = s_next.dly.on ? s_next.dly.value : CFC_VALUE_RST;
    s_next.abs_ro = s_next.expo.auto_mode || !s_next.expo.abs_ctl || !s_next.expo.on;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign pready          = s_reg.pready;
  assign pslverr         = s_reg.pslverr;
  assign prdata          = s_reg.prdata;
  assign defect_corr_en  = s_reg.defect_on;
  assign exposure_en     = s_reg.expo.on;
  assign exposure_auto   = s_reg.expo.auto_mode;
  assign exposure_value  = {s_reg.expo.high, s_reg.expo.value};
  assign abs_exposure_ro = s_reg.abs_ro;
  assign one_push_start  = s_reg.push_start;
  assign trigger_fire    = s_reg.fire;
  assign trigger_en      = s_reg.trig.on;
  assign trigger_mode    = s_reg.trig.mode;
  assign trigger_param   = s_reg.trig.param;
  assign trigger_delay   = s_reg.delay_out;

  //////////////////////////////////////////////////////////////////////////////
  // off feature keeps fields
  AST_EXPO_FROZEN_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !s_reg.expo.on && !s_next.expo.on |=> $stable(s_reg.expo.auto_mode) && $stable(s_reg.expo.abs_ctl))
    else $error("exposure field changed while feature off");
  AST_AUTO_VALUE: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.expo.on && s_reg.expo.auto_mode |=> s_reg.expo.value == $past(auto_exposure_value))
    else $error("auto exposure value not tracked");
  AST_PUSH_AUTO: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.expo.auto_mode && !s_reg.expo.one_push |=> !s_reg.expo.one_push)
    else $error("one push started in auto mode");
  AST_STICKY_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.busy && s_reg.trig.mode == CFC_STICKY_MODE && !wr_acc |=> s_reg.busy)
    else $error("busy cleared itself in sticky mode");
  AST_SELF_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    trigger_done && s_reg.trig.mode != CFC_STICKY_MODE && !ext_event && !wr_acc |=> !s_reg.busy)
    else $error("busy not self-cleared");
  AST_FIRE_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.fire |-> s_reg.busy)
    else $error("fire without busy");
  AST_SOFT_FIRE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == CFC_SOFT_FIRE_ADDR && pwdata[CFC_FIRE_BIT] |=> trigger_fire && s_reg.busy)
    else $error("software fire not taken");
  AST_EXT_FIRE: assert property (@(posedge pclk) disable iff (!presetn)
    ext_event |=> trigger_fire && s_reg.busy)
    else $error("external trigger edge not taken");
  AST_DELAY_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !s_reg.dly.on |-> s_reg.delay_out == CFC_VALUE_RST)
    else $error("delay applied while off");
  AST_RAW_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
    $stable(s_reg.trig.source) |=> s_reg.trig.raw == $past(pin_level))
    else $error("raw pin level not reflected");
  AST_RESERVED: assert property (@(posedge pclk) disable iff (!presetn)
    pready && paddr == CFC_TRIG_DELAY_ADDR |-> prdata[19:7] == 13'h0000 && prdata[5:2] == 4'h0)
    else $error("reserved delay bits nonzero");
  AST_ABS_OPEN: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.expo.on && s_reg.expo.abs_ctl && !s_reg.expo.auto_mode |-> !abs_exposure_ro)
    else $error("absolute register locked in absolute state");
  AST_ABS_LOCKED: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.expo.on && !s_reg.expo.abs_ctl |-> abs_exposure_ro)
    else $error("absolute register open in plain manual state");
  AST_DEFECT_SWITCH: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == CFC_DEFECT_ADDR |=> defect_corr_en == $past(pwdata[CFC_ON_BIT]))
    else $error("correction switch not written");
  AST_TRIG_FROZEN: assert property (@(posedge pclk) disable iff (!presetn)
    !s_reg.trig.on && !s_next.trig.on |=> $stable(s_reg.trig.mode) && $stable(s_reg.trig.polarity))
    else $error("trigger field changed while feature off");
  AST_PARAM_RO: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.trig.abs_ctl |=> $stable(s_reg.trig.param))
    else $error("trigger parameter written under absolute control");

endmodule // cfc_regs

/* src/cfc_pkg.sv */
// cfc_pkg: constants and types for the camera feature control register bank
// assumes a 32-bit apb slave with byte addresses below 8 kbyte
package cfc_pkg;

  // register byte addresses
  localparam logic [12:0] CFC_SOFT_FIRE_ADDR   = 13'h062c;
  localparam logic [12:0] CFC_EXPOSURE_ADDR    = 13'h081c;
  localparam logic [12:0] CFC_TRIG_BEHAV_ADDR  = 13'h0830;
  localparam logic [12:0] CFC_TRIG_DELAY_ADDR  = 13'h0834;
  localparam logic [12:0] CFC_DEFECT_ADDR      = 13'h1a60;

  // field positions, lsb of the word is bit 0
  localparam int CFC_PRESENT_BIT  = 0;
  localparam int CFC_ABS_BIT      = 1;
  localparam int CFC_ONE_PUSH_BIT = 5;
  localparam int CFC_ON_BIT       = 6;
  localparam int CFC_AUTO_BIT     = 7;
  localparam int CFC_POL_BIT      = 7;
  localparam int CFC_SRC_LSB      = 8;
  localparam int CFC_RAW_BIT      = 11;
  localparam int CFC_MODE_LSB     = 12;
  localparam int CFC_HIGH_LSB     = 8;
  localparam int CFC_MAXPIX_LSB   = 8;
  localparam int CFC_VALUE_LSB    = 20;
  localparam int CFC_FIRE_BIT     = 0;

  // trigger mode whose fire bit stays set until software clears it
  localparam logic [3:0]  CFC_STICKY_MODE = 4'h3;
  localparam logic [11:0] CFC_VALUE_RST   = 12'h000;
  localparam logic [31:0] CFC_RDATA_RST   = 32'h0000_0000;

  typedef struct packed {
    logic        on;
    logic        abs_ctl;
    logic        auto_mode;
    logic        one_push;
    logic [3:0]  high;
    logic [11:0] value;
  } cfc_exposure_t;

  typedef struct packed {
    logic        on;
    logic        abs_ctl;
    logic        polarity;
    logic [2:0]  source;
    logic        raw;
    logic        raw_active_d;
    logic [3:0]  mode;
    logic [11:0] param;
  } cfc_trig_t;

  typedef struct packed {
    logic        on;
    logic        abs_ctl;
    logic [11:0] value;
  } cfc_delay_t;

  typedef struct packed {
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
    logic          defect_on;
    cfc_exposure_t expo;
    cfc_trig_t     trig;
    cfc_delay_t    dly;
    logic          busy;
    logic          fire;
    logic          push_start;
    logic [11:0]   delay_out;
    logic          abs_ro;
  } cfc_state_t;

endpackage : cfc_pkg

/* testbench/cfc_regs_test.sv */
// cfc_regs_test: self-checking bench for the camera feature register bank
// assumes cfc_pkg is compiled first; apb answer time is never assumed
`timescale 1ns/1ns
module cfc_regs_test;
  import cfc_pkg::*;
  localparam logic [11:0] MAXP  = 12'h0a5c;
  localparam int          LIMIT = 20000;
  localparam logic [32:0] ALL   = 33'h1_ffff_ffff;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, one_push_done, trigger_done;
  logic [12:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [11:0] defect_cur_pixels, abs_exposure_value, auto_exposure_value, trigger_param, trigger_delay, v, p;
  logic [7:0]  gpio_in;
  logic        defect_corr_en, exposure_en, exposure_auto, abs_exposure_ro, one_push_start, trigger_fire, trigger_en;
  logic [15:0] exposure_value;
  logic [3:0]  trigger_mode, h;
  logic [2:0]  src;
  logic [1:0]  pulses;
  logic [65:0] notes[$];
  int          miscompares = 0, check_count = 0, cycles = 0;

  cfc_regs #(.PIN_COUNT(8), .DEFECT_MAX_PIX(MAXP)) cfc_regs_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .defect_cur_pixels(defect_cur_pixels), .abs_exposure_value(abs_exposure_value),
    .auto_exposure_value(auto_exposure_value), .one_push_done(one_push_done), .trigger_done(trigger_done),
    .gpio_in(gpio_in), .defect_corr_en(defect_corr_en), .exposure_en(exposure_en), .exposure_auto(exposure_auto),
    .exposure_value(exposure_value), .abs_exposure_ro(abs_exposure_ro), .one_push_start(one_push_start),
    .trigger_fire(trigger_fire), .trigger_en(trigger_en), .trigger_mode(trigger_mode),
    .trigger_param(trigger_param), .trigger_delay(trigger_delay));
  assign pulses = {trigger_fire, one_push_start};

  ////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // hang guard: far above the few hundred cycles the sequence needs
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      $display("mismatch timeout: expected finish seen none");
      summarize();
    end
  end

  task automatic chk_rd(input logic [32:0] e, input logic [32:0] m, input logic [32:0] g);
    check_count++;
    if ((g & m) !== (e & m)) begin
      miscompares++;
      $display("mismatch apb answer: expected %h seen %h mask %h", e, g, m);
    end
  endtask

  task automatic chk_out(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s: expected %h seen %h", nm, e, g);
    end
  endtask

  // second process: oldest note against each completed transfer
  always @(posedge pclk) begin : watch
    logic [65:0] n;
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (notes.size() == 0) begin
        miscompares++;
        $display("mismatch apb answer: expected none seen %h", prdata);
      end else begin
        n = notes.pop_front();
        chk_rd(n[65:33], n[32:0], {pslverr, prdata});
      end
    end
  end

  ////////////////////////////////////////
  task automatic xfer(input logic w, input logic [12:0] a, input logic [31:0] d, input logic [32:0] e,
                      input logic [32:0] m);
    @(posedge pclk);
    notes.push_back({e, m});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [12:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 33'h0, 33'h1_0000_0000);
  endtask

  task automatic rd(input logic [12:0] a, input logic [31:0] e, input logic [31:0] m);
    xfer(1'b0, a, 32'h0, {1'b0, e}, {1'b1, m});
  endtask

  task automatic strobe(input int idx);
    @(posedge pclk);
    if (idx == 0) one_push_done <= 1'b1;
    else trigger_done <= 1'b1;
    @(posedge pclk);
    one_push_done <= 1'b0;
    trigger_done  <= 1'b0;
  endtask

  // single-cycle pulse expected within a few cycles
  task automatic wait_pulse(input string nm, input int idx);
    for (int k = 0; k < 4 && pulses[idx] !== 1'b1; k++) @(negedge pclk);
    chk_out(nm, 32'h1, {31'h0, pulses[idx]});
    @(negedge pclk);
    chk_out(nm, 32'h0, {31'h0, pulses[idx]});
  endtask

  function automatic logic [31:0] tw(input logic [11:0] pp, input logic [3:0] md, input logic [7:0] c);
    return {pp, 4'h0, md, 1'b0, src, c};
  endfunction

  ////////////////////////////////////////
  initial begin
    void'($urandom(32'h46b1));
    {presetn, psel, penable, pwrite, one_push_done, trigger_done} = 6'h00;
    paddr = 13'h0000;
    pwdata = 32'h0000_0000;
    {defect_cur_pixels, abs_exposure_value, auto_exposure_value} = 36'({$urandom, $urandom});
    {v, p, h, src} = 31'($urandom);
    gpio_in = 8'($urandom);
    gpio_in[src] = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(CFC_DEFECT_ADDR, {defect_cur_pixels, MAXP, 8'h01}, 32'hffff_ffff);
    rd(CFC_EXPOSURE_ADDR, 32'h0000_0001, 32'hffff_ffff);
    rd(CFC_TRIG_BEHAV_ADDR, 32'h0000_0001, 32'hffff_f7ff);
    rd(CFC_TRIG_DELAY_ADDR, 32'h0000_0001, 32'hffff_ffff);
    xfer(1'b0, 13'h0004, 32'h0, 33'h1_0000_0000, ALL);
    $display("test reset_values done");
    wr(CFC_DEFECT_ADDR, 32'hffff_ffff);
    rd(CFC_DEFECT_ADDR, {defect_cur_pixels, MAXP, 8'h41}, 32'hffff_ffff);
    chk_out("defect_corr_en", 32'h1, {31'h0, defect_corr_en});
    $display("test defect done");
    wr(CFC_EXPOSURE_ADDR, {v, 8'hff, h, 8'h40});
    rd(CFC_EXPOSURE_ADDR, 32'h0000_0041, 32'hffff_ffff);
    chk_out("exposure_en", 32'h1, {31'h0, exposure_en});
    wr(CFC_EXPOSURE_ADDR, {v, 8'hff, h, 8'h5c});
    rd(CFC_EXPOSURE_ADDR, {v, 8'h00, h, 8'h41}, 32'hffff_ffff);
    chk_out("exposure_value", {16'h0, h, v}, {16'h0, exposure_value});
    wr(CFC_EXPOSURE_ADDR, {v, 8'h00, h, 8'h60});
    wait_pulse("one_push_start", 0);
    rd(CFC_EXPOSURE_ADDR, 32'h0000_0020, 32'h0000_0020);
    strobe(0);
    rd(CFC_EXPOSURE_ADDR, 32'h0000_0000, 32'h0000_0020);
    wr(CFC_EXPOSURE_ADDR, {~v, 8'h00, h, 8'hc0});
    rd(CFC_EXPOSURE_ADDR, {auto_exposure_value, 20'h000c0}, 32'hfff0_00c0);
    chk_out("abs_exposure_ro", 32'h1, {31'h0, abs_exposure_ro});
    chk_out("exposure_auto", 32'h1, {31'h0, exposure_auto});
    wr(CFC_EXPOSURE_ADDR, {~v, 8'h00, h, 8'he0});
    rd(CFC_EXPOSURE_ADDR, {auto_exposure_value, 20'h000c0}, 32'hfff0_00e0);
    wr(CFC_EXPOSURE_ADDR, {~v, 8'h00, h, 8'h42});
    rd(CFC_EXPOSURE_ADDR, {abs_exposure_value, 20'h00042}, 32'hfff0_00c2);
    chk_out("abs_exposure_ro", 32'h0, {31'h0, abs_exposure_ro});
    wr(CFC_EXPOSURE_ADDR, {v, 8'h00, h, 8'h40});
    wr(CFC_EXPOSURE_ADDR, {v, 8'h00, h, 8'h40});
    rd(CFC_EXPOSURE_ADDR, {v, 20'h00040}, 32'hfff0_00c2);
    chk_out("abs_exposure_ro", 32'h1, {31'h0, abs_exposure_ro});
    chk_out("exposure_auto", 32'h0, {31'h0, exposure_auto});
    $display("test exposure done");
    wr(CFC_TRIG_BEHAV_ADDR, 32'h0000_0040);
    wr(CFC_TRIG_BEHAV_ADDR, tw(p, 4'h1, 8'hfc) | 32'h000f_0800);
    wr(CFC_SOFT_FIRE_ADDR, 32'h0000_0000);
    rd(CFC_TRIG_BEHAV_ADDR, tw(p, 4'h1, 8'hc1), 32'hffff_ffff);
    chk_out("trigger_param", {20'h0, p}, {20'h0, trigger_param});
    gpio_in[src] <= 1'b1;
    wait_pulse("trigger_fire", 1);
    rd(CFC_SOFT_FIRE_ADDR, 32'h0000_0001, 32'hffff_ffff);
    rd(CFC_TRIG_BEHAV_ADDR, 32'h0000_0800, 32'h0000_0800);
    strobe(1);
    rd(CFC_SOFT_FIRE_ADDR, 32'h0000_0000, 32'hffff_ffff);
    for (int md = 0; md < 16; md++) begin
      wr(CFC_TRIG_BEHAV_ADDR, tw(p, 4'(md), 8'hc0));
      rd(CFC_TRIG_BEHAV_ADDR, {16'h0, 4'(md), 12'h0}, 32'h0000_f000);
      chk_out("trigger_mode", 32'(md), {28'h0, trigger_mode});
    end
    wr(CFC_TRIG_BEHAV_ADDR, tw(p, CFC_STICKY_MODE, 8'hc0));
    wr(CFC_SOFT_FIRE_ADDR, 32'h0000_0001);
    wait_pulse("trigger_fire", 1);
    rd(CFC_SOFT_FIRE_ADDR, 32'h0000_0001, 32'hffff_ffff);
    strobe(1);
    rd(CFC_SOFT_FIRE_ADDR, 32'h0000_0001, 32'hffff_ffff);
    wr(CFC_SOFT_FIRE_ADDR, 32'h0000_0000);
    rd(CFC_SOFT_FIRE_ADDR, 32'h0000_0000, 32'hffff_ffff);
    wr(CFC_TRIG_BEHAV_ADDR, tw(p, CFC_STICKY_MODE, 8'hc2));
    wr(CFC_TRIG_BEHAV_ADDR, tw(~p, CFC_STICKY_MODE, 8'hc2));
    rd(CFC_TRIG_BEHAV_ADDR, {p, 20'h00002}, 32'hfff0_0002);
    wr(CFC_TRIG_BEHAV_ADDR, tw(~p, CFC_STICKY_MODE, 8'h00));
    wr(CFC_TRIG_BEHAV_ADDR, tw(~p, 4'h0, 8'h80));
    rd(CFC_TRIG_BEHAV_ADDR, 32'h0000_3000, 32'h0000_f0c0);
    chk_out("trigger_en", 32'h0, {31'h0, trigger_en});
    $display("test trigger done");
    wr(CFC_TRIG_DELAY_ADDR, 32'h0000_0040);
    wr(CFC_TRIG_DELAY_ADDR, {v, 12'hfff, 8'hfc});
    rd(CFC_TRIG_DELAY_ADDR, {v, 20'h00041}, 32'hffff_ffff);
    chk_out("trigger_delay", {20'h0, v}, {20'h0, trigger_delay});
    wr(CFC_TRIG_DELAY_ADDR, {v, 20'h00000});
    rd(CFC_TRIG_DELAY_ADDR, {v, 20'h00001}, 32'hffff_ffff);
    chk_out("trigger_delay", 32'h0, {20'h0, trigger_delay});
    $display("test delay done");
    repeat (3) @(posedge pclk);
    summarize();
  end
endmodule // cfc_regs_test
